/* File: rtl/card_slot_pkg.sv */
/*
 Shared constants for the per-slot socket control block: register indices,
 field positions, reset values and the DMA request source encoding.
 Assumes an 8-bit index/data register port on the ISA side.
*/
package card_slot_pkg;

    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_IDENTITY = 8'h00;
    localparam logic [7:0] IDX_IF_STATUS = 8'h01;
    localparam logic [7:0] IDX_POWER_CTRL = 8'h02;
    localparam logic [7:0] IDX_GEN_CTRL = 8'h03;
    localparam logic [7:0] IDX_MODE_CTRL2 = 8'h2d;
    localparam logic [7:0] IDX_MODE_CTRL3 = 8'h2e;
    localparam logic [7:0] IDX_MIXED_VOLT = 8'h2f;
    // Highest index that this slot answers to
    localparam logic [7:0] IDX_LAST = 8'h3f;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PWR_OUT_EN = 7;
    localparam int PWR_KEEP_ON_RESUME = 6;
    localparam int PWR_AUTO_SWITCH = 5;
    localparam int PWR_ON = 4;
    localparam int PWR_VPP_HI = 1;
    localparam int PWR_VPP_LO = 0;
    localparam int GEN_RING_ENABLE = 7;
    localparam int GEN_IO_CARD = 5;
    localparam int MC3_DMA_ENABLE = 1;
    localparam int MC3_TC_ON_IRQ15 = 4;
    localparam int MC2_DREQ_HI = 7;
    localparam int MC2_DREQ_LO = 6;
    localparam int MV_3V_SELECT = 0;
    localparam int STS_GENERAL_IN = 7;
    localparam int STS_POWER = 6;
    localparam int STS_READY = 5;
    localparam int STS_WRITE_PROT = 4;
    localparam int STS_CD2 = 3;
    localparam int STS_CD1 = 2;
    localparam int STS_BVD2 = 1;
    localparam int STS_BVD1 = 0;

    localparam logic [7:0] REG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Card DMA request source
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DREQ_IOIS16 = 2'b00,
        DREQ_SPKR = 2'b01,
        DREQ_INPACK = 2'b10,
        DREQ_NONE = 2'b11
    } dreq_src_e;

endpackage

/* File: rtl/socket_if.sv */
/*
 Carrier between the slot top and its status and power helpers.
 Assumes all pin levels in it are already synchronised to mclk.
*/
`timescale 1ns/1ns
interface socket_if;
    logic generalInN;
    logic cd1N;
    logic cd2N;
    logic rdyIreq;
    logic wpIois16;
    logic bvd1Stschg;
    logic bvd2Spkr;
    logic ioCard;
    logic ringEnable;
    logic dreqOnWp;
    logic powerActive;
    logic [7:0] powerCtrl;
    logic mixed3v;
    logic [7:0] statusByte;
    logic vcc3nNext;
    logic vcc5nNext;
    logic vpp1Next;
    logic vpp0Next;

    modport top (
        output generalInN, cd1N, cd2N, rdyIreq, wpIois16, bvd1Stschg, bvd2Spkr,
        output ioCard, ringEnable, dreqOnWp, powerActive, powerCtrl, mixed3v,
        input statusByte, vcc3nNext, vcc5nNext, vpp1Next, vpp0Next
    );
    modport status (
        input generalInN, cd1N, cd2N, rdyIreq, wpIois16, bvd1Stschg, bvd2Spkr,
        input ioCard, ringEnable, dreqOnWp, powerActive,
        output statusByte
    );
    modport power (
        input powerCtrl, mixed3v, cd1N, cd2N,
        output vcc3nNext, vcc5nNext, vpp1Next, vpp0Next
    );
endinterface

/* File: rtl/socket_status.sv */
/*
 Builds the interface status byte from synchronised slot pins.
 Assumes the carrier holds settled mclk-domain levels; purely combinational.
*/
`timescale 1ns/1ns
module socket_status
    import card_slot_pkg::*;
(
    socket_if.status sif
);
    always_comb begin
        sif.statusByte[STS_GENERAL_IN] = ~sif.generalInN;
        sif.statusByte[STS_POWER] = sif.powerActive;
        sif.statusByte[STS_READY] = sif.rdyIreq;
        // A DMA request on this pin is active low; show it as a high level
        sif.statusByte[STS_WRITE_PROT] =
            sif.dreqOnWp ? ~sif.wpIois16 : sif.wpIois16;
        sif.statusByte[STS_CD2] = ~sif.cd2N;
        sif.statusByte[STS_CD1] = ~sif.cd1N;
        if (!sif.ioCard) begin
            sif.statusByte[STS_BVD2] = sif.bvd2Spkr;
            sif.statusByte[STS_BVD1] = sif.bvd1Stschg;
        end else begin
            sif.statusByte[STS_BVD2] = 1'b0;
            sif.statusByte[STS_BVD1] = sif.ringEnable ? 1'b0 : sif.bvd1Stschg;
        end
    end
endmodule

/* File: rtl/socket_power.sv */
/*
 Decodes the power control byte into the socket power-switch enables.
 Assumes the card-detect levels are synchronised; purely combinational.
*/
`timescale 1ns/1ns
module socket_power
    import card_slot_pkg::*;
(
    socket_if.power sif
);
    logic cardSeated;
    logic drive;

    always_comb begin
        cardSeated = ~sif.cd1N && ~sif.cd2N;
        drive = sif.powerCtrl[PWR_ON]
            && (cardSeated || !sif.powerCtrl[PWR_AUTO_SWITCH]);
        if (drive) begin
            sif.vpp1Next = sif.powerCtrl[PWR_VPP_HI];
            sif.vpp0Next = sif.powerCtrl[PWR_VPP_LO];
            sif.vcc3nNext = ~sif.mixed3v;
            sif.vcc5nNext = sif.mixed3v;
        end else begin
            // Inactive pattern, also used when auto switching drops power
            sif.vcc3nNext = 1'b1;
            sif.vcc5nNext = 1'b1;
            sif.vpp1Next = 1'b1;
            sif.vpp0Next = 1'b0;
        end
    end
endmodule

/* File: rtl/card_slot_ctrl.sv */
/*
 Per-slot DMA mode and socket control: index/data register port on the ISA
 side, DMA pin reuse, status reporting and power-switch enables.
 Assumes ISA strobes and slot pins are asynchronous to mclk, and that the
 card cycle logic supplies OE#, WE# and REG# strobes on mclk.
*/
`timescale 1ns/1ns
module card_slot_ctrl
    import card_slot_pkg::*;
#(
    // Arbitrary identity values, not tied to any product
    parameter logic [1:0] CARD_TYPES = 2'b10,
    parameter logic [3:0] REVISION = 4'h5
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic isaCsN,
    input wire logic isaDataSel,
    input wire logic isaIorN,
    input wire logic isaIowN,
    input wire logic [7:0] isaDataIn,
    output logic [7:0] isaDataOut,
    output logic isaDataOe,
    input wire logic resetDrive,
    input wire logic power_good_input,
    input wire logic general_purpose_input,
    input wire logic cd1N,
    input wire logic cd2N,
    input wire logic rdyIreq,
    input wire logic wpIois16,
    input wire logic bvd1Stschg,
    input wire logic bvd2Spkr,
    input wire logic inpackN,
    input wire logic irq9DackN,
    input wire logic irq11Tc,
    input wire logic irq15Tc,
    output logic irq10Dreq,
    output logic irq10DreqOe,
    output logic irqDmaOwned,
    input wire logic cycleOeN,
    input wire logic cycleWeN,
    input wire logic cycleRegN,
    output logic cardOeN,
    output logic cardWeN,
    output logic cardRegN,
    output logic slotCtrlOe,
    output logic speaker_output_n,
    output logic vcc_3v_enable_n,
    output logic vcc_5v_enable_n,
    output logic vpp_select_1,
    output logic vpp_select_0
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic csN;
        logic dataSel;
        logic iorN;
        logic iowN;
        logic [7:0] data;
        logic resetDrive;
        logic powerGood;
        logic generalInN;
        logic cd1N;
        logic cd2N;
        logic rdyIreq;
        logic wpIois16;
        logic bvd1Stschg;
        logic bvd2Spkr;
        logic inpackN;
        logic dackN;
        logic tc11;
        logic tc15;
    } pin_s;

    typedef struct packed {
        pin_s syncA;
        pin_s syncB;
        logic iowPrev;
        logic wrCs;
        logic wrSel;
        logic [7:0] wrData;
        logic [7:0] index;
        logic [7:0] powerCtrl;
        logic [7:0] genCtrl;
        logic [7:0] modeCtrl2;
        logic [7:0] modeCtrl3;
        logic [7:0] mixedVolt;
        logic [7:0] dataOut;
        logic dataOe;
        logic dreq;
        logic dreqOe;
        logic dmaOwned;
        logic oeN;
        logic weN;
        logic regN;
        logic ctrlOe;
        logic speakerN;
        logic vcc3n;
        logic vcc5n;
        logic vpp1;
        logic vpp0;
    } state_s;

    localparam state_s STATE_RESET = '{
        syncA: '1, syncB: '1, iowPrev: 1'b1, wrCs: 1'b0, wrSel: 1'b0,
        wrData: REG_RESET, index: REG_RESET, powerCtrl: REG_RESET,
        genCtrl: REG_RESET, modeCtrl2: REG_RESET, modeCtrl3: REG_RESET,
        mixedVolt: REG_RESET, dataOut: REG_RESET, dataOe: 1'b0,
        dreq: 1'b0, dreqOe: 1'b0, dmaOwned: 1'b0, oeN: 1'b1, weN: 1'b1,
        regN: 1'b1, ctrlOe: 1'b0, speakerN: 1'b1, vcc3n: 1'b1, vcc5n: 1'b1,
        vpp1: 1'b1, vpp0: 1'b0
    };

    state_s st;
    state_s next_st;
    pin_s pinsNow;
    pin_s p;
    socket_if sif ();

    logic dmaOn;
    logic dackOn;
    logic tcLevel;
    logic dreqLevel;
    logic writeDone;
    logic keepRegs;
    dreq_src_e dreqSrc;

    // ----------------------------------------------------------------
    // Register read decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] read_reg(input logic [7:0] idx, input state_s s,
                                            input logic [7:0] status);
        logic [7:0] val;
        val = REG_RESET;
        case (idx)
            IDX_IDENTITY: val = {CARD_TYPES, 2'b00, REVISION};
            IDX_IF_STATUS: val = status;
            IDX_POWER_CTRL: val = s.powerCtrl;
            IDX_GEN_CTRL: val = s.genCtrl;
            IDX_MODE_CTRL2: val = s.modeCtrl2;
            IDX_MODE_CTRL3: val = s.modeCtrl3;
            IDX_MIXED_VOLT: val = s.mixedVolt;
            default: val = REG_RESET;
        endcase
        return val;
    endfunction

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    socket_status statusUnit (
        .sif(sif.status)
    );

    socket_power powerUnit (
        .sif(sif.power)
    );

    always_comb begin
        pinsNow = '{
            csN: isaCsN, dataSel: isaDataSel, iorN: isaIorN, iowN: isaIowN,
            data: isaDataIn, resetDrive: resetDrive, powerGood: power_good_input,
            generalInN: general_purpose_input, cd1N: cd1N, cd2N: cd2N,
            rdyIreq: rdyIreq, wpIois16: wpIois16, bvd1Stschg: bvd1Stschg,
            bvd2Spkr: bvd2Spkr, inpackN: inpackN, dackN: irq9DackN,
            tc11: irq11Tc, tc15: irq15Tc
        };
        p = st.syncB;

        dmaOn = st.modeCtrl3[MC3_DMA_ENABLE];
        dreqSrc = dreq_src_e'({st.modeCtrl2[MC2_DREQ_HI], st.modeCtrl2[MC2_DREQ_LO]});
        // I/O card typing and the INPACK# bit2 constraint are left to software
        unique case (dreqSrc)
            DREQ_IOIS16: dreqLevel = ~p.wpIois16;
            DREQ_SPKR: dreqLevel = ~p.bvd2Spkr;
            DREQ_INPACK: dreqLevel = ~p.inpackN;
            DREQ_NONE: dreqLevel = 1'b0;
        endcase
        tcLevel = st.modeCtrl3[MC3_TC_ON_IRQ15] ? p.tc15 : p.tc11;
        dackOn = dmaOn && !p.dackN;

        sif.generalInN = p.generalInN;
        sif.cd1N = p.cd1N;
        sif.cd2N = p.cd2N;
        sif.rdyIreq = p.rdyIreq;
        sif.wpIois16 = p.wpIois16;
        sif.bvd1Stschg = p.bvd1Stschg;
        sif.bvd2Spkr = p.bvd2Spkr;
        sif.ioCard = st.genCtrl[GEN_IO_CARD];
        sif.ringEnable = st.genCtrl[GEN_RING_ENABLE];
        sif.dreqOnWp = dmaOn && (dreqSrc == DREQ_IOIS16);
        sif.powerActive = !st.vcc3n || !st.vcc5n;
        sif.powerCtrl = st.powerCtrl;
        sif.mixed3v = st.mixedVolt[MV_3V_SELECT];
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.syncA = pinsNow;
        next_st.syncB = st.syncA;

        // Address and data are caught while the write strobe is low, since
        // chip select may already be gone on the cycle the strobe rises
        next_st.iowPrev = p.iowN;
        if (!p.iowN) begin
            next_st.wrCs = !p.csN;
            next_st.wrSel = p.dataSel;
            next_st.wrData = p.data;
        end
        writeDone = p.iowN && !st.iowPrev && st.wrCs;

        if (writeDone) begin
            if (!st.wrSel) begin
                next_st.index = st.wrData;
            end else begin
                case (st.index)
                    IDX_POWER_CTRL: next_st.powerCtrl = st.wrData;
                    IDX_GEN_CTRL: next_st.genCtrl = st.wrData;
                    IDX_MODE_CTRL2: next_st.modeCtrl2 = st.wrData;
                    IDX_MODE_CTRL3: next_st.modeCtrl3 = st.wrData;
                    IDX_MIXED_VOLT: next_st.mixedVolt = st.wrData;
                    default: next_st.index = st.index;
                endcase
            end
        end

        // Reset drive clears the register set unless a resume keeps it
        keepRegs = st.powerCtrl[PWR_KEEP_ON_RESUME] && p.powerGood;
        if (p.resetDrive && !keepRegs) begin
            next_st.index = REG_RESET;
            next_st.powerCtrl = REG_RESET;
            next_st.genCtrl = REG_RESET;
            next_st.modeCtrl2 = REG_RESET;
            next_st.modeCtrl3 = REG_RESET;
            next_st.mixedVolt = REG_RESET;
        end

        // Data reads at indices outside this slot leave the data bus floating
        next_st.dataOe = !p.csN && !p.iorN && (!p.dataSel || st.index <= IDX_LAST);
        next_st.dataOut = p.dataSel ? read_reg(st.index, st, sif.statusByte) : st.index;

        next_st.dreq = dmaOn && dreqLevel;
        next_st.dreqOe = dmaOn;
        next_st.dmaOwned = dmaOn;
        next_st.oeN = cycleOeN && !(dackOn && tcLevel && !p.iorN);
        next_st.weN = cycleWeN && !(dackOn && tcLevel && !p.iowN);
        next_st.regN = dackOn ? 1'b1 : cycleRegN;
        next_st.ctrlOe = st.powerCtrl[PWR_OUT_EN];
        // SPKR# carries the card's request in this mode, so it is not echoed
        next_st.speakerN = (dmaOn && dreqSrc == DREQ_SPKR) ? 1'b1 : p.bvd2Spkr;

        next_st.vcc3n = sif.vcc3nNext;
        next_st.vcc5n = sif.vcc5nNext;
        next_st.vpp1 = sif.vpp1Next;
        next_st.vpp0 = sif.vpp0Next;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign isaDataOut = st.dataOut;
    assign isaDataOe = st.dataOe;
    assign irq10Dreq = st.dreq;
    assign irq10DreqOe = st.dreqOe;
    assign irqDmaOwned = st.dmaOwned;
    assign cardOeN = st.oeN;
    assign cardWeN = st.weN;
    assign cardRegN = st.regN;
    assign slotCtrlOe = st.ctrlOe;
    assign speaker_output_n = st.speakerN;
    assign vcc_3v_enable_n = st.vcc3n;
    assign vcc_5v_enable_n = st.vcc5n;
    assign vpp_select_1 = st.vpp1;
    assign vpp_select_0 = st.vpp0;

endmodule

/* File: tb/card_slot_monitor.sv */
/*
 Checker for the slot control block, watching its top ports only.
 Assumes it is bound to card_slot_ctrl from the bench top.
*/
`timescale 1ns/1ns
module card_slot_monitor (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic isaCsN,
    input wire logic isaDataSel,
    input wire logic isaIorN,
    input wire logic isaDataOe,
    input wire logic irq9DackN,
    input wire logic irq10DreqOe,
    input wire logic irqDmaOwned,
    input wire logic cycleOeN,
    input wire logic cycleWeN,
    input wire logic cardOeN,
    input wire logic cardWeN,
    input wire logic cardRegN,
    input wire logic vcc_3v_enable_n,
    input wire logic vcc_5v_enable_n,
    input wire logic vpp_select_1,
    input wire logic vpp_select_0
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    chk_index_read: assert property (
        (!isaCsN && !isaIorN && !isaDataSel)[*4] |-> isaDataOe)
        else $error("index read not driven");
    chk_read_release: assert property (isaIorN[*4] |-> !isaDataOe)
        else $error("data bus driven after read");
    chk_dma_owned: assert property (irqDmaOwned == irq10DreqOe)
        else $error("request driver and pin ownership differ");
    chk_reg_high: assert property ((irqDmaOwned && !irq9DackN)[*4] |-> cardRegN)
        else $error("attribute strobe low during transfer");
    chk_oe_pass: assert property (!cycleOeN |=> !cardOeN)
        else $error("read strobe not passed");
    chk_we_pass: assert property (!cycleWeN |=> !cardWeN)
        else $error("write strobe not passed");
    chk_one_rail: assert property (!(!vcc_3v_enable_n && !vcc_5v_enable_n))
        else $error("both supply enables active");
    chk_off_pattern: assert property (
        vcc_3v_enable_n && vcc_5v_enable_n |-> vpp_select_1 && !vpp_select_0)
        else $error("programming supply wrong while off");
    chk_reset_state: assert property (
        $rose(rstn) |-> !isaDataOe && !irqDmaOwned && cardRegN && vcc_5v_enable_n)
        else $error("outputs not idle after reset");

    cover property (irqDmaOwned && !irq9DackN);
    cover property (isaDataOe);
    cover property (!vcc_3v_enable_n);
endmodule

/* File: tb/slot_partner.sv */
/*
 Far-side model: a card in the slot whose pin levels the bench commands.
 Assumes pin order {general input, cd2, cd1, rdy, wp, bvd2, bvd1, inpack}.
*/
`timescale 1ns/1ns
module slot_partner (
    input wire logic mclk,
    input wire logic [7:0] pinCmd,
    output logic generalInPin,
    output logic cd2N,
    output logic cd1N,
    output logic rdyIreq,
    output logic wpIois16,
    output logic bvd2Spkr,
    output logic bvd1Stschg,
    output logic inpackN
);
    // Pins move just after the edge, and the controller samples them on the next mclk edge
    always_ff @(posedge mclk)
        {generalInPin, cd2N, cd1N, rdyIreq, wpIois16, bvd2Spkr, bvd1Stschg, inpackN} <= pinCmd;
endmodule

/* File: tb/tb_top.sv */
/*
 Self-checking bench for the slot control block.
 Assumes the design package and carrier interface are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
    import card_slot_pkg::*;
    // Arbitrary identity values
    localparam logic [1:0] TYPES = 2'b01;
    localparam logic [3:0] REV = 4'h9;
    logic mclk = 1'b0, rstn = 1'b0, isaCsN = 1'b1, isaDataSel = 1'b0;
    logic isaIorN = 1'b1, isaIowN = 1'b1, resetDrive = 1'b0, powerGood = 1'b1;
    logic irq9DackN = 1'b1, irq11Tc = 1'b0, irq15Tc = 1'b0;
    logic cycleOeN = 1'b1, cycleWeN = 1'b1, cycleRegN = 1'b1;
    logic [7:0] isaDataIn = 8'h00, pinCmd = 8'h9f, isaDataOut;
    logic isaDataOe, irq10Dreq, irq10DreqOe, irqDmaOwned, cardOeN, cardWeN, cardRegN;
    logic slotCtrlOe, speaker_output_n, vcc_3v_enable_n, vcc_5v_enable_n;
    logic vpp_select_1, vpp_select_0, generalInPin, cd1N, cd2N, rdyIreq, wpIois16;
    logic bvd1Stschg, bvd2Spkr, inpackN;
    logic [31:0] seed = 32'had96;
    int num_errors = 0, cmp_count = 0, cycles = 0;

    slot_partner card (.mclk, .pinCmd, .generalInPin, .cd2N, .cd1N, .rdyIreq, .wpIois16,
        .bvd2Spkr, .bvd1Stschg, .inpackN);
    card_slot_ctrl #(.CARD_TYPES(TYPES), .REVISION(REV)) DUT (.mclk, .rstn, .isaCsN,
        .isaDataSel, .isaIorN, .isaIowN, .isaDataIn, .isaDataOut, .isaDataOe, .resetDrive,
        .power_good_input(powerGood), .general_purpose_input(generalInPin), .cd1N, .cd2N,
        .rdyIreq, .wpIois16, .bvd1Stschg, .bvd2Spkr, .inpackN, .irq9DackN, .irq11Tc,
        .irq15Tc, .irq10Dreq, .irq10DreqOe, .irqDmaOwned, .cycleOeN, .cycleWeN, .cycleRegN,
        .cardOeN, .cardWeN, .cardRegN, .slotCtrlOe, .speaker_output_n, .vcc_3v_enable_n,
        .vcc_5v_enable_n, .vpp_select_1, .vpp_select_0);

    initial begin
        forever #10 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [3:0] expPower(input logic [7:0] pc, input logic mv,
                                           input logic [1:0] cd);
        if (!pc[PWR_ON] || (pc[PWR_AUTO_SWITCH] && cd != 2'b00))
            return 4'b1110;
        return {~mv, mv, pc[PWR_VPP_HI], pc[PWR_VPP_LO]};
    endfunction

    function automatic logic [7:0] expStatus(input logic [7:0] p, input logic pwr,
                                            input logic [7:0] gc);
        logic [1:0] bvd;
        bvd = {p[2], p[1]};
        if (gc[GEN_IO_CARD])
            bvd = {1'b0, p[1] & ~gc[GEN_RING_ENABLE]};
        return {~p[7], pwr, p[4], p[3], ~p[6], ~p[5], bvd};
    endfunction

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wrByte(input logic sel, input logic [7:0] v);
        @(posedge mclk);
        isaDataSel <= sel;
        isaDataIn <= v;
        isaCsN <= 1'b0;
        isaIowN <= 1'b0;
        repeat (4) @(posedge mclk);
        isaIowN <= 1'b1;
        repeat (2) @(posedge mclk);
        isaCsN <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic regWrite(input logic [7:0] idx, input logic [7:0] v);
        wrByte(1'b0, idx);
        wrByte(1'b1, v);
    endtask

    task automatic regRead(input logic [7:0] idx, input logic sel, output logic [7:0] d,
                           output logic oe);
        int n;
        wrByte(1'b0, idx);
        @(posedge mclk);
        isaDataSel <= sel;
        isaCsN <= 1'b0;
        isaIorN <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (isaDataOe !== 1'b1 && n < 8);
        d = isaDataOut;
        oe = isaDataOe;
        @(posedge mclk);
        isaCsN <= 1'b1;
        isaIorN <= 1'b1;
        repeat (5) @(posedge mclk);
    endtask

    // Drive {dack, tc11, tc15, ior, iow}, then compare {oe, we, reg} strobes
    // Cycle logic asks for REG# low, so a high REG# shows the DMA override
    task automatic dmaProbe(input string name, input logic [4:0] drv, input logic [7:0] exp);
        @(posedge mclk);
        {irq9DackN, irq11Tc, irq15Tc, isaIorN, isaIowN} <= drv;
        cycleRegN <= 1'b0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        check(name, exp, {5'h00, cardOeN, cardWeN, cardRegN});
        @(posedge mclk);
        {irq9DackN, irq11Tc, irq15Tc, isaIorN, isaIowN} <= 5'b10011;
        cycleRegN <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d, pc, p, gc;
        logic oe, mv;
        logic [3:0] pw;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        regWrite(IDX_IDENTITY, 8'hff);
        regRead(IDX_IDENTITY, 1'b1, d, oe);
        check("identity", {TYPES, 2'b00, REV}, d);
        regRead(IDX_POWER_CTRL, 1'b1, d, oe);
        check("power reset", REG_RESET, d);
        regRead(8'h41, 1'b0, d, oe);
        check("index port", 8'h41, d);
        regRead(8'h41, 1'b1, d, oe);
        check("unmapped drive", 8'h00, {7'h00, oe});
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            pc = seed[7:0];
            mv = seed[8];
            gc = {seed[9], 1'b0, seed[10], 5'h00};
            p = seed[23:16];
            if (i < 2) begin
                pc = 8'hb3;
                p = {seed[23], 1'b0, i[0], seed[20:16]};
            end
            pinCmd <= p;
            cycleOeN <= seed[11];
            cycleWeN <= seed[12];
            cycleRegN <= seed[13];
            regWrite(IDX_POWER_CTRL, pc);
            regWrite(IDX_MIXED_VOLT, {7'h00, mv});
            regWrite(IDX_GEN_CTRL, gc);
            @(negedge mclk);
            pw = expPower(pc, mv, {p[5], p[6]});
            check("power pins", {4'h0, pw}, {4'h0, vcc_3v_enable_n, vcc_5v_enable_n,
                vpp_select_1, vpp_select_0});
            check("slot enable", {7'h00, pc[PWR_OUT_EN]}, {7'h00, slotCtrlOe});
            regRead(IDX_IF_STATUS, 1'b1, d, oe);
            check("status", expStatus(p, pw[3:2] != 2'b11, gc),
                d);
            regRead(IDX_POWER_CTRL, 1'b1, d, oe);
            check("power readback", pc, d);
        end
        @(posedge mclk);
        pinCmd <= 8'h9f;
        cycleOeN <= 1'b1;
        cycleWeN <= 1'b1;
        cycleRegN <= 1'b1;
        regWrite(IDX_GEN_CTRL, 8'h20);
        regWrite(IDX_MODE_CTRL3, 8'h02);
        @(negedge mclk);
        check("dma pins", 8'h03, {6'h00, irqDmaOwned, irq10DreqOe});
        for (int s = 0; s < 3; s++) begin
            regWrite(IDX_MODE_CTRL2, {s[1:0], 6'h00});
            pinCmd <= (s == 0) ? 8'h97 : (s == 1) ? 8'h9b : 8'h9e;
            repeat (6) @(posedge mclk);
            @(negedge mclk);
            check("dreq active", 8'h01, {7'h00, irq10Dreq});
            if (s == 1)
                check("speaker", 8'h01, {7'h00, speaker_output_n});
            if (s == 0) begin
                regRead(IDX_IF_STATUS, 1'b1, d, oe);
                check("status dreq", 8'h10, d & 8'h10);
            end
            @(posedge mclk);
            pinCmd <= 8'h9f;
            repeat (6) @(posedge mclk);
            @(negedge mclk);
            check("dreq idle", 8'h00, {7'h00, irq10Dreq});
        end
        dmaProbe("tc on read", 5'b01001, 8'h03);
        dmaProbe("tc on write", 5'b01010, 8'h05);
        regWrite(IDX_MODE_CTRL3, 8'h12);
        dmaProbe("tc other line", 5'b01001, 8'h07);
        dmaProbe("tc high line", 5'b00101, 8'h03);
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            powerGood <= (k == 0);
            regWrite(IDX_POWER_CTRL, 8'h40);
            @(posedge mclk);
            resetDrive <= 1'b1;
            repeat (4) @(posedge mclk);
            resetDrive <= 1'b0;
            repeat (4) @(posedge mclk);
            regRead(IDX_POWER_CTRL, 1'b1, d, oe);
            check("kept on resume", (k == 0) ? 8'h40 : 8'h00, d);
            regRead(IDX_MODE_CTRL3, 1'b1, d, oe);
            check("mode after reset", (k == 0) ? 8'h12 : 8'h00, d);
        end
        end_of_test();
    end
endmodule

bind card_slot_ctrl card_slot_monitor u_mon (.mclk, .rstn, .isaCsN, .isaDataSel, .isaIorN,
    .isaDataOe, .irq9DackN, .irq10DreqOe, .irqDmaOwned, .cycleOeN, .cycleWeN, .cardOeN,
    .cardWeN, .cardRegN, .vcc_3v_enable_n, .vcc_5v_enable_n, .vpp_select_1, .vpp_select_0);
